//--- rtl/sas_adc_seq.sv
// Chosen here: register access over Wishbone.
module sas_adc_seq
    import sas_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Device environment
    input wire logic sleep_i,
    input wire logic rc_tick_i,
    input wire logic cmp_i,
    // Analog front end and status
    output sas_afe_t afe_o,
    output logic done_flag_o
);
    logic ack_r, ack_nxt;
    logic [31:0] dat_r, dat_nxt;
    logic [1:0] clksel_r, clksel_nxt;
    logic [2:0] chan_r, chan_nxt;
    logic go_r, go_nxt;
    logic pwr_on_r, pwr_on_nxt;
    logic [2:0] pcfg_r, pcfg_nxt;
    logic flag_r, flag_nxt;
    logic [RES_W-1:0] result_r, result_nxt;
    sas_state_t state_r, state_nxt;
    logic [2:0] dly_r, dly_nxt;
    logic [1:0] abt_r, abt_nxt;
    logic [3:0] conv_ticks_r, conv_ticks_nxt;
    sas_afe_t afe_r, afe_nxt;
    logic wr;
    logic pwr_act;
    logic tick;
    logic sar_start;
    logic sar_abort;
    logic sar_done;
    logic [RES_W-1:0] sar_res;
    logic [RES_W-1:0] sar_trial;
    logic [7:0] ctrl0_rd;

    // Sleep halts the converter unless the RC clock drives it
    assign pwr_act = pwr_on_r
        && !(sleep_i && clksel_r != CLK_RC);

    sas_tad_gen #(
        .MAX_DIV(DIV_FOSC32)
    ) u_tad (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(pwr_act),
        .sel_i(clksel_r),
        .rc_tick_i(rc_tick_i),
        .tick_o(tick)
    );

    sas_sar u_sar (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(sar_start),
        .abort_i(sar_abort),
        .tick_i(tick),
        .cmp_i(cmp_i),
        .trial_o(sar_trial),
        .result_o(sar_res),
        .done_o(sar_done)
    );

    always_comb begin
        ctrl0_rd = {clksel_r, chan_r, go_r, 1'b0, pwr_on_r};
        wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_r && wb_sel_i[0];
        ack_nxt = wb_cyc_i && wb_stb_i && !ack_r;
        dat_nxt = dat_r;
        clksel_nxt = clksel_r;
        chan_nxt = chan_r;
        go_nxt = go_r;
        pwr_on_nxt = pwr_on_r;
        pcfg_nxt = pcfg_r;
        flag_nxt = flag_r;
        result_nxt = result_r;
        state_nxt = state_r;
        dly_nxt = dly_r;
        abt_nxt = abt_r;
        conv_ticks_nxt = conv_ticks_r;
        sar_start = 1'b0;
        sar_abort = 1'b0;
        if (ack_nxt) begin
            case (wb_adr_i[ADR_W-1:2])
                IDX_CTRL0: dat_nxt = {24'h0, ctrl0_rd};
                IDX_PINCFG: dat_nxt = {29'h0, pcfg_r};
                IDX_RESULT: dat_nxt = {24'h0, result_r};
                IDX_STATUS: dat_nxt = {31'h0, flag_r};
                default: dat_nxt = 32'h0;
            endcase
        end
        if (wr) begin
            case (wb_adr_i[ADR_W-1:2])
                IDX_CTRL0: begin
                    clksel_nxt = wb_dat_i[CLKSEL_HI:CLKSEL_LO];
                    chan_nxt = wb_dat_i[CHAN_HI:CHAN_LO];
                    pwr_on_nxt = wb_dat_i[PWR_BIT];
                    // Go only counts if power was already on
                    go_nxt = wb_dat_i[GO_BIT] && pwr_on_r
                        && wb_dat_i[PWR_BIT];
                end
                IDX_PINCFG: pcfg_nxt = wb_dat_i[PCFG_HI:0];
                IDX_RESULT: result_nxt = wb_dat_i[RES_W-1:0];
                IDX_STATUS: flag_nxt = wb_dat_i[FLAG_BIT];
                default: ;
            endcase
        end
        if (!pwr_act) begin
            // Power off or sleep on a non-RC clock: drop the state, go and the SAR run
            state_nxt = ST_OFF;
            go_nxt = 1'b0;
            sar_abort = 1'b1;
        end else begin
            case (state_r)
                ST_OFF: state_nxt = ST_IDLE;
                ST_IDLE: begin
                    conv_ticks_nxt = 4'h0;
                    if (go_r && clksel_r == CLK_RC) begin
                        state_nxt = ST_DELAY;
                        dly_nxt = 3'(RC_START_CYCLES - 1);
                    end else if (go_r) begin
                        state_nxt = ST_SAMPLE;
                    end
                end
                ST_DELAY: begin
                    if (!go_r) begin
                        state_nxt = ST_IDLE;
                    end else if (dly_r == 3'h0) begin
                        state_nxt = ST_SAMPLE;
                    end else begin
                        dly_nxt = dly_r - 3'h1;
                    end
                end
                ST_SAMPLE: begin
                    if (!go_r) begin
                        state_nxt = ST_ABORT;
                        abt_nxt = 2'h0;
                    end else if (tick) begin
                        state_nxt = ST_CONV;
                        sar_start = 1'b1;
                        conv_ticks_nxt = conv_ticks_r + 4'h1;
                    end
                end
                ST_CONV: begin
                    if (tick) begin
                        conv_ticks_nxt = conv_ticks_r + 4'h1;
                    end
                    if (!go_r) begin
                        state_nxt = ST_ABORT;
                        abt_nxt = 2'h0;
                        sar_abort = 1'b1;
                    end else if (sar_done) begin
                        // Hardware clear of go and set of flag win
                        state_nxt = ST_IDLE;
                        result_nxt = sar_res;
                        go_nxt = 1'b0;
                        flag_nxt = 1'b1;
                    end
                end
                ST_ABORT: begin
                    if (tick && abt_r == 2'(ABORT_PERIODS - 1)) begin
                        state_nxt = ST_IDLE;
                    end else if (tick) begin
                        abt_nxt = abt_r + 2'h1;
                    end
                end
                default: state_nxt = ST_OFF;
            endcase
        end
    end

    always_comb begin
        afe_nxt.power = pwr_act;
        afe_nxt.sample = pwr_act && (state_r == ST_IDLE
            || state_r == ST_DELAY || state_r == ST_SAMPLE);
        afe_nxt.chan = chan_r;
        afe_nxt.trial = sar_trial;
        case (pcfg_r)
            3'h0, 3'h2: begin
                afe_nxt.analog = 5'h1F;
                afe_nxt.ref_ext = 1'b0;
            end
            3'h1, 3'h3: begin
                afe_nxt.analog = 5'h17;
                afe_nxt.ref_ext = 1'b1;
            end
            3'h4: begin
                afe_nxt.analog = 5'h0B;
                afe_nxt.ref_ext = 1'b0;
            end
            3'h5: begin
                afe_nxt.analog = 5'h03;
                afe_nxt.ref_ext = 1'b1;
            end
            default: begin
                afe_nxt.analog = 5'h00;
                afe_nxt.ref_ext = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0;
            clksel_r <= CLKSEL_RST;
            chan_r <= CHAN_RST;
            go_r <= 1'b0;
            pwr_on_r <= 1'b0;
            pcfg_r <= PCFG_RST;
            flag_r <= 1'b0;
            state_r <= ST_OFF;
            dly_r <= 3'h0;
            abt_r <= 2'h0;
            conv_ticks_r <= 4'h0;
            afe_r <= '0;
        end else begin
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
            clksel_r <= clksel_nxt;
            chan_r <= chan_nxt;
            go_r <= go_nxt;
            pwr_on_r <= pwr_on_nxt;
            pcfg_r <= pcfg_nxt;
            flag_r <= flag_nxt;
            state_r <= state_nxt;
            dly_r <= dly_nxt;
            abt_r <= abt_nxt;
            conv_ticks_r <= conv_ticks_nxt;
            afe_r <= afe_nxt;
        end
    end

    // Result keeps its content through reset
    always_ff @(posedge clk_i) begin
        result_r <= result_nxt;
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign afe_o = afe_r;
    assign done_flag_o = flag_r;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_sw_abort;
        state_r == ST_CONV && !go_r && pwr_act;
    endsequence
    sequence s_abort_entry;
        state_r == ST_ABORT && $stable(result_r);
    endsequence

    AST_RESET_OFF: assert property (disable iff (1'b0)
        rst_i |=> !pwr_on_r && !go_r && state_r == ST_OFF)
        else $error("reset did not power the converter off");
    AST_GO_NEEDS_POWER: assert property (
        $rose(go_r) |-> $past(pwr_on_r))
        else $error("go set while power was off");
    AST_DONE_SETS_FLAG: assert property (
        state_r == ST_CONV && go_r && pwr_act && sar_done
        |=> flag_r && !go_r && result_r == $past(sar_res))
        else $error("completion did not load result and flag");
    AST_ABORT_KEEPS_RESULT: assert property (
        s_sw_abort |=> s_abort_entry)
        else $error("abort changed the result");
    AST_ABORT_TWO_PERIODS: assert property (
        state_r == ST_ABORT && tick && abt_r == 2'h1 && pwr_act
        |=> state_r == ST_IDLE)
        else $error("abort wait not two bit periods");
    AST_NINE_PERIODS: assert property (
        state_r == ST_CONV && sar_done
        |-> conv_ticks_r == 4'(CONV_PERIODS))
        else $error("conversion length not nine bit periods");
    AST_SLEEP_ABORT: assert property (
        sleep_i && clksel_r != CLK_RC |=> state_r == ST_OFF
        && !afe_o.power)
        else $error("non-RC conversion survived sleep");
    AST_RESERVED_ZERO: assert property (
        ack_nxt && wb_adr_i[ADR_W-1:2] == IDX_CTRL0
        |=> wb_ack_o && !wb_dat_o[1])
        else $error("unimplemented control bit read as one");
    AST_ACK_ONE_CYCLE: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
endmodule

//--- rtl/sas_pkg.sv
package sas_pkg;
    // Wishbone byte address is four times the register index
    localparam int ADR_W = 10;
    localparam logic [7:0] IDX_RESULT = 8'h1E;
    localparam logic [7:0] IDX_CTRL0 = 8'h1F;
    localparam logic [7:0] IDX_PINCFG = 8'h9F;
    localparam logic [7:0] IDX_STATUS = 8'hA0;

    // Field positions in converter_control_0
    localparam int CLKSEL_HI = 7;
    localparam int CLKSEL_LO = 6;
    localparam int CHAN_HI = 5;
    localparam int CHAN_LO = 3;
    localparam int GO_BIT = 2;
    localparam int PWR_BIT = 0;
    // Field positions in converter_pin_config and the status register
    localparam int PCFG_HI = 2;
    localparam int FLAG_BIT = 0;

    // Reset values
    localparam logic [1:0] CLKSEL_RST = 2'h0;
    localparam logic [2:0] CHAN_RST = 3'h0;
    localparam logic [2:0] PCFG_RST = 3'h0;

    // conv_clock_select codes and oscillator divisors
    localparam logic [1:0] CLK_DIV2 = 2'h0;
    localparam logic [1:0] CLK_DIV8 = 2'h1;
    localparam logic [1:0] CLK_DIV32 = 2'h2;
    localparam logic [1:0] CLK_RC = 2'h3;
    localparam int DIV_FOSC2 = 2;
    localparam int DIV_FOSC8 = 8;
    localparam int DIV_FOSC32 = 32;

    // Result width and cycle counts
    localparam int RES_W = 8;
    localparam int CONV_PERIODS = 9;
    localparam int ABORT_PERIODS = 2;
    localparam int RC_START_CYCLES = 4;

    typedef enum logic [2:0] {
        ST_OFF, ST_IDLE, ST_DELAY, ST_SAMPLE, ST_CONV, ST_ABORT
    } sas_state_t;

    // Everything the analog front end needs, in one bundle
    typedef struct packed {
        logic power;
        logic sample;
        logic [2:0] chan;
        logic ref_ext;
        logic [4:0] analog;
        logic [7:0] trial;
    } sas_afe_t;
endpackage

//--- rtl/sas_tad_gen.sv
module sas_tad_gen
    import sas_pkg::*;
#(
    parameter int MAX_DIV = 32
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control
    input wire logic run_i,
    input wire logic [1:0] sel_i,
    input wire logic rc_tick_i,
    // One pulse per bit period
    output logic tick_o
);
    if (MAX_DIV < DIV_FOSC32) begin : g_chk
        $error("MAX_DIV too small for the largest divisor");
    end

    logic [5:0] cnt_r;
    logic [5:0] cnt_nxt;
    logic [5:0] last;
    logic tick_r;
    logic tick_nxt;

    always_comb begin
        case (sel_i)
            CLK_DIV2: last = 6'(DIV_FOSC2 - 1);
            CLK_DIV8: last = 6'(DIV_FOSC8 - 1);
            default: last = 6'(DIV_FOSC32 - 1);
        endcase
        cnt_nxt = 6'h0;
        tick_nxt = 1'b0;
        if (run_i) begin
            if (sel_i == CLK_RC) begin
                tick_nxt = rc_tick_i;
            end else if (cnt_r >= last) begin
                tick_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 6'h1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r <= 6'h0;
            tick_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick_o = tick_r;

    AST_DIV2_RATE: assert property (@(posedge clk_i) disable iff (rst_i)
        tick_o && run_i && sel_i == CLK_DIV2
        ##1 run_i && sel_i == CLK_DIV2
        |=> tick_o)
        else $error("divide-by-2 bit period broken");
    AST_DIV8_GAP: assert property (@(posedge clk_i) disable iff (rst_i)
        tick_o && sel_i == CLK_DIV8 |=> !tick_o [*7])
        else $error("divide-by-8 tick came too early");
endmodule

//--- rtl/sas_sar.sv
module sas_sar
    import sas_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Sequencing
    input wire logic start_i,
    input wire logic abort_i,
    input wire logic tick_i,
    input wire logic cmp_i,
    // Results
    output logic [RES_W-1:0] trial_o,
    output logic [RES_W-1:0] result_o,
    output logic done_o
);
    logic [RES_W-1:0] trial_r;
    logic [RES_W-1:0] trial_nxt;
    logic [RES_W-1:0] res_r;
    logic [RES_W-1:0] res_nxt;
    logic [2:0] idx_r;
    logic [2:0] idx_nxt;
    logic busy_r;
    logic busy_nxt;
    logic done_r;
    logic done_nxt;
    logic [RES_W-1:0] kept;

    always_comb begin
        trial_nxt = trial_r;
        res_nxt = res_r;
        idx_nxt = idx_r;
        busy_nxt = busy_r;
        done_nxt = 1'b0;
        kept = trial_r;
        kept[idx_r] = cmp_i;
        if (abort_i) begin
            busy_nxt = 1'b0;
        end else if (start_i) begin
            trial_nxt = 8'h80;
            idx_nxt = 3'h7;
            busy_nxt = 1'b1;
        end else if (busy_r && tick_i) begin
            // One decision per bit period, MSB down to LSB
            if (idx_r == 3'h0) begin
                res_nxt = kept;
                trial_nxt = kept;
                busy_nxt = 1'b0;
                done_nxt = 1'b1;
            end else begin
                trial_nxt = kept | (8'h01 << (idx_r - 3'h1));
                idx_nxt = idx_r - 3'h1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trial_r <= 8'h00;
            res_r <= 8'h00;
            idx_r <= 3'h0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            trial_r <= trial_nxt;
            res_r <= res_nxt;
            idx_r <= idx_nxt;
            busy_r <= busy_nxt;
            done_r <= done_nxt;
        end
    end

    assign trial_o = trial_r;
    assign result_o = res_r;
    assign done_o = done_r;

    AST_MSB_FIRST: assert property (@(posedge clk_i) disable iff (rst_i)
        start_i && !abort_i |=> trial_o == 8'h80)
        else $error("conversion did not start at the MSB");
    AST_DONE_RESULT: assert property (@(posedge clk_i) disable iff (rst_i)
        done_o |-> result_o == trial_o)
        else $error("result differs from final trial");
endmodule

//--- verification/sas_afe_model.sv
module sas_afe_model
    import sas_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Front-end controls from the sequencer, and the analog input level
    input wire sas_afe_t afe_i,
    input wire logic [7:0] level_i,
    // Comparator decision
    output logic cmp_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic last_r = 1'b0;

    // An unpowered comparator gives no valid answer, so flip it
    always @(posedge clk_i) begin
        if (afe_i.power) begin
            last_r <= (level_i >= afe_i.trial);
        end else begin
            last_r <= ~last_r;
        end
    end

    always_comb begin
        if (afe_i.power) begin
            cmp_o = (level_i >= afe_i.trial);
        end else begin
            cmp_o = ~last_r;
        end
    end
endmodule

//--- verification/sas_adc_seq_tb.sv
module sas_adc_seq_tb
    import sas_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // RC bit period of 2.5 us, inside the allowed window
    localparam int RC_P = 100;
    logic clk, rst, wb_we, wb_cyc, wb_stb, wb_ack, sleep, cmp, flag;
    logic rc_tick = 1'b0;
    logic [ADR_W-1:0] wb_adr;
    logic [31:0] wb_wdat, wb_rdat, rd;
    logic [3:0] wb_sel;
    logic [7:0] level;
    logic [7:0] rc_cnt = 8'h00;
    sas_afe_t afe;
    int miscompares, comparisons;
    logic [4:0] am [8] = '{5'h1F, 5'h17, 5'h1F, 5'h17,
        5'h0B, 5'h03, 5'h00, 5'h00};
    logic [7:0] refmap = 8'h2A;

    sas_adc_seq dut_u (.clk_i(clk), .rst_i(rst), .wb_adr_i(wb_adr),
        .wb_dat_i(wb_wdat), .wb_sel_i(wb_sel), .wb_we_i(wb_we),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_dat_o(wb_rdat),
        .wb_ack_o(wb_ack), .sleep_i(sleep), .rc_tick_i(rc_tick),
        .cmp_i(cmp), .afe_o(afe), .done_flag_o(flag));

    sas_afe_model afe_u (.clk_i(clk), .afe_i(afe), .level_i(level),
        .cmp_o(cmp));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Free-running RC oscillator, unrelated to the divider phase
    always @(posedge clk) begin
        rc_cnt <= (rc_cnt == 8'(RC_P - 1)) ? 8'h00 : rc_cnt + 8'h01;
        rc_tick <= (rc_cnt == 8'h03);
    end

    task automatic final_report();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] idx,
        input logic [7:0] wd, output logic [31:0] rdat);
        @(posedge clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= {idx, 2'b00};
        wb_wdat <= {24'h000000, wd};
        do begin
            @(posedge clk);
        end while (wb_ack !== 1'b1);
        rdat = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        wb(1'b1, idx, d, rd);
    endtask

    task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
        wb(1'b0, idx, 8'h00, rd);
        chk(rd, {24'h000000, exp});
    endtask

    task automatic convert(input logic [1:0] code, input logic [2:0] ch,
        input logic [7:0] lv, input int per);
        int n;
        level <= lv;
        wr(IDX_CTRL0, {code, ch, 3'b001});
        repeat (640) @(posedge clk);
        wr(IDX_CTRL0, {code, ch, 3'b101});
        chk({29'h0, afe.chan}, {29'h0, ch});
        n = 0;
        while (flag !== 1'b1 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        chk({31'h0, n >= 8 * per && n <= 9 * per + 16}, 32'h1);
        rdc(IDX_CTRL0, {code, ch, 3'b001});
        rdc(IDX_RESULT, lv);
        rdc(IDX_STATUS, 8'h01);
        wr(IDX_STATUS, 8'h00);
        rdc(IDX_STATUS, 8'h00);
        repeat (2 * per + 2) @(posedge clk);
    endtask

    initial begin
        #(25ns * 30000);
        miscompares++;
        final_report();
    end

    initial begin
        rst = 1'b1;
        wb_cyc = 1'b0;
        wb_stb = 1'b0;
        wb_we = 1'b0;
        wb_adr = '0;
        wb_wdat = '0;
        wb_sel = 4'hF;
        sleep = 1'b0;
        level = 8'h00;
        miscompares = 0;
        comparisons = 0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdc(IDX_CTRL0, 8'h00);
        rdc(IDX_PINCFG, 8'h00);
        rdc(IDX_STATUS, 8'h00);
        rdc(8'h10, 8'h00);
        chk({13'h0, afe}, 32'h00001F00);
        // Go with power off must be dropped, loose bits read zero
        wr(IDX_CTRL0, 8'hFE);
        rdc(IDX_CTRL0, 8'hF8);
        chk({31'h0, afe.power}, 32'h0);
        wr(IDX_PINCFG, 8'hFF);
        rdc(IDX_PINCFG, 8'h07);
        wr(IDX_CTRL0, 8'h01);
        repeat (2) @(posedge clk);
        chk({31'h0, afe.power}, 32'h1);
        for (int c = 0; c < 8; c++) begin
            wr(IDX_PINCFG, 8'(c));
            repeat (2) @(posedge clk);
            chk({27'h0, afe.analog}, {27'h0, am[c]});
            chk({31'h0, afe.ref_ext}, {31'h0, refmap[c]});
        end
        wr(IDX_PINCFG, 8'h00);
        convert(CLK_DIV2, 3'h4, 8'hFF, DIV_FOSC2);
        convert(CLK_DIV8, 3'h1, 8'h01, DIV_FOSC8);
        convert(CLK_DIV32, 3'h2, 8'hA5, DIV_FOSC32);
        // The RC clock keeps converting while the device sleeps
        sleep <= 1'b1;
        convert(CLK_RC, 3'h3, 8'h3C, RC_P);
        sleep <= 1'b0;
        // Abort mid-conversion keeps the old result
        wr(IDX_RESULT, 8'h5A);
        rdc(IDX_RESULT, 8'h5A);
        level <= 8'hC3;
        wr(IDX_CTRL0, 8'h81);
        wr(IDX_CTRL0, 8'h85);
        repeat (60) @(posedge clk);
        wr(IDX_CTRL0, 8'h81);
        repeat (3 * DIV_FOSC32 + 4) @(posedge clk);
        rdc(IDX_CTRL0, 8'h81);
        rdc(IDX_RESULT, 8'h5A);
        rdc(IDX_STATUS, 8'h00);
        chk({31'h0, afe.sample}, 32'h1);
        // Sleep on a divided clock stops the conversion
        wr(IDX_CTRL0, 8'h45);
        repeat (20) @(posedge clk);
        sleep <= 1'b1;
        repeat (10) @(posedge clk);
        chk({31'h0, afe.power}, 32'h0);
        rdc(IDX_CTRL0, 8'h41);
        sleep <= 1'b0;
        rdc(IDX_STATUS, 8'h00);
        // Reset in mid-conversion
        wr(IDX_PINCFG, 8'h05);
        wr(IDX_CTRL0, 8'h85);
        repeat (30) @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdc(IDX_CTRL0, 8'h00);
        rdc(IDX_PINCFG, 8'h00);
        rdc(IDX_RESULT, 8'h5A);
        chk({13'h0, afe}, 32'h00001F00);
        repeat (400) @(posedge clk);
        chk({31'h0, flag}, 32'h0);
        final_report();
    end
endmodule
